//--- hw/fcst_defs.svh
`ifndef FCST_DEFS_SVH
`define FCST_DEFS_SVH

// ------------
// Word indices
// ------------
`define FCST_IDX_CTRL      30'h0000_40a0
`define FCST_IDX_RX_USH    30'h0000_40a7
`define FCST_IDX_RX_USL    30'h0000_40a8
`define FCST_IDX_RX_IERR   30'h0000_40a9
`define FCST_IDX_RX_OERR   30'h0000_40aa
`define FCST_IDX_RX_FRAG   30'h0000_40ab
`define FCST_IDX_RX_NOSFD  30'h0000_40ac
`define FCST_IDX_TX_GDH    30'h0000_40ad
`define FCST_IDX_TX_GDL    30'h0000_40ae
`define FCST_IDX_TX_OSH    30'h0000_40af
`define FCST_IDX_TX_OSL    30'h0000_40b0
`define FCST_IDX_TX_USH    30'h0000_40b1
`define FCST_IDX_TX_USL    30'h0000_40b2
`define FCST_IDX_TX_IERR   30'h0000_40b3
`define FCST_IDX_TX_OERR   30'h0000_40b4
`define FCST_IDX_TX_FRAG   30'h0000_40b5
`define FCST_IDX_TX_NOSFD  30'h0000_40b6
`define FCST_IDX_CFG2      30'h0000_40b7
`define FCST_IDX_IRQ_STAT  30'h0000_4100
`define FCST_IDX_IRQ_MASK  30'h0000_4101

// ------------
// Fields
// ------------
`define FCST_BIT_CHK_EN    15
`define FCST_BIT_TX_SRC    1
`define FCST_IRQ_W         4

// ------------
// Reset values
// ------------
`define FCST_RST_CNT       16'h0000
`define FCST_RST_IRQ       4'h0

// ------------
// Frame limits, delimiter and CRC constants
// ------------
`define FCST_LEN_MIN       11'h040
`define FCST_LEN_MAX       11'h5ee
`define FCST_NIB_MAX       12'hfff
`define FCST_SFD_NIB       4'hd
`define FCST_CRC_INIT      32'hffff_ffff
`define FCST_CRC_POLY      32'hedb8_8320
`define FCST_CRC_RESIDUE   32'hdebb_20e3

`endif

//--- hw/fcst_pkg.sv
package fcst_pkg;

  // Frame monitor states, one-hot
  typedef enum logic [2:0] {
    FCST_FM_IDLE = 3'h1,
    FCST_FM_PRE  = 3'h2,
    FCST_FM_DATA = 3'h4
  } fcst_fm_state_t;

  // Classification of one finished frame
  typedef struct packed {
    logic nosfd;
    logic frag;
    logic under_good;
    logic inr_good;
    logic inr_bad;
    logic over_good;
    logic over_bad;
  } fcst_class_t;

endpackage

//--- hw/fcst_rc_cnt.sv
`timescale 1ns/10ps
`include "fcst_defs.svh"

// 16-bit read-to-clear counter with carry out
module fcst_rc_cnt (
  input  wire logic        mclk_i,  // Core clock
  input  wire logic        rst_b_i, // Reset, low
  input  wire logic        inc_i,   // Count one
  input  wire logic        clr_i,   // Read clear
  output logic [15:0]      val_o,   // Count value
  output logic             cy_o     // Wrap carry
);

  logic [15:0] cnt_ff;     // Count
  logic [15:0] nxt_cnt;    // Next count

  // A clear keeps an increment of the same cycle
  assign nxt_cnt = (clr_i ? 16'h0000 : cnt_ff) + {15'h0000, inc_i};
  // Carry only when the kept value wraps
  assign cy_o    = inc_i & ~clr_i & (&cnt_ff);
  assign val_o   = cnt_ff;

  // Count register
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_ff <= `FCST_RST_CNT;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule // fcst_rc_cnt

//--- hw/fcst_frame_mon.sv
`timescale 1ns/10ps
`include "fcst_defs.svh"

// Delimits one nibble stream into frames, checks CRC and measures length
module fcst_frame_mon
  import fcst_pkg::*;
(
  input  wire logic        mclk_i,   // Core clock
  input  wire logic        rst_b_i,  // Reset, low
  input  wire logic        run_i,    // Checker on
  input  wire logic        dv_i,     // Data valid
  input  wire logic [3:0]  nib_i,    // Nibble, low first
  input  wire logic        stb_i,    // Nibble strobe
  output logic             done_o,   // Frame end pulse
  output logic [10:0]      len_o,    // Bytes after delimiter
  output logic             crc_ok_o, // CRC good
  output logic             sfd_ok_o  // Delimiter seen
);

  // Reflected CRC step over one nibble
  function automatic logic [31:0] crc_nib(input logic [31:0] c, input logic [3:0] d);
    logic [31:0] r;
    r = c;
    for (int k = 0; k < 4; k++) begin
      r = (r[0] ^ d[k]) ? ((r >> 1) ^ `FCST_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  fcst_fm_state_t state_ff;  // Frame state
  fcst_fm_state_t nxt_state; // Next state
  logic [31:0]    crc_ff;    // Running CRC
  logic [31:0]    nxt_crc;   // Next CRC
  logic [11:0]    ncnt_ff;   // Data nibbles
  logic [11:0]    nxt_ncnt;  // Next nibbles
  logic           take;      // Nibble taken
  logic           is_sfd;    // Delimiter nibble
  logic           in_data;   // Past delimiter
  logic           ends;      // Frame closes

  assign take    = stb_i & dv_i;
  assign is_sfd  = (nib_i == `FCST_SFD_NIB);
  assign in_data = (state_ff == FCST_FM_DATA);
  assign ends    = ~dv_i & (state_ff != FCST_FM_IDLE) & run_i;

  // Preamble and delimiter are not counted
  // (RL16) length from DA
  assign nxt_ncnt = !in_data ? 12'h000 :
                    (take && ncnt_ff != `FCST_NIB_MAX) ? ncnt_ff + 12'h001 : ncnt_ff;
  assign nxt_crc  = !in_data ? `FCST_CRC_INIT :
                    take ? crc_nib(crc_ff, nib_i) : crc_ff;

  // Next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      FCST_FM_IDLE: if (take) begin
        nxt_state = is_sfd ? FCST_FM_DATA : FCST_FM_PRE;
      end
      FCST_FM_PRE: if (!dv_i) begin
        nxt_state = FCST_FM_IDLE;
      end else if (take && is_sfd) begin
        nxt_state = FCST_FM_DATA;
      end
      FCST_FM_DATA: if (!dv_i) begin
        nxt_state = FCST_FM_IDLE;
      end
      default: nxt_state = FCST_FM_IDLE;
    endcase
    // Disabled checker holds idle
    if (!run_i) begin
      nxt_state = FCST_FM_IDLE;
    end
  end

  // State and running values
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= FCST_FM_IDLE;
      crc_ff   <= `FCST_CRC_INIT;
      ncnt_ff  <= 12'h000;
    end else begin
      state_ff <= nxt_state;
      crc_ff   <= nxt_crc;
      ncnt_ff  <= nxt_ncnt;
    end
  end

  // Frame result, odd nibble dropped
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_o   <= 1'b0;
      len_o    <= 11'h000;
      crc_ok_o <= 1'b0;
      sfd_ok_o <= 1'b0;
    end else begin
      done_o <= ends;
      if (ends) begin
        len_o    <= ncnt_ff[11:1];
        crc_ok_o <= in_data & (crc_ff == `FCST_CRC_RESIDUE);
        sfd_ok_o <= in_data;
      end
    end
  end

endmodule // fcst_frame_mon

//--- hw/fcst_top.sv
`timescale 1ns/10ps
`include "fcst_defs.svh"

// Operation
// (RL1) rx short good frames, 32-bit
// (RL2) rx in-range CRC errors
// (RL3) rx oversize CRC errors
// (RL4) rx short frames as fragments
// (RL5) rx frames missing delimiter
// (RL6) tx in-range good frames, 32-bit
// (RL7) tx oversize good frames, 32-bit
// (RL8) tx short good frames, 32-bit
// (RL9) tx in-range CRC errors
// (RL10) tx oversize CRC errors
// (RL11) tx short frames as fragments
// (RL12) tx frames missing delimiter
// (RL13) count only while checker enabled
// (RL14) select tx checker data source
// (RL15) zero at reset, clear on read
// (RL16) length counts DA through CRC
module fcst_top
  import fcst_pkg::*;
(
  input  wire logic        mclk_i,      // Core clock
  input  wire logic        rst_b_i,     // Reset, low
  input  wire logic        psel_i,      // APB select
  input  wire logic        penable_i,   // APB enable
  input  wire logic        pwrite_i,    // APB write
  input  wire logic [31:0] paddr_i,     // APB address
  input  wire logic [31:0] pwdata_i,    // APB write data
  output logic [31:0]      prdata_o,    // APB read data
  output logic             pready_o,    // APB ready
  output logic             pslverr_o,   // APB error
  output logic             irq_o,       // Interrupt
  input  wire logic        rx_dv_i,     // Wire rx valid
  input  wire logic [3:0]  rx_nib_i,    // Wire rx nibble
  input  wire logic        rx_stb_i,    // Wire rx strobe
  input  wire logic        mii_tx_en_i, // MAC tx valid
  input  wire logic [3:0]  mii_txd_i,   // MAC tx nibble
  input  wire logic        mii_stb_i,   // MAC tx strobe
  input  wire logic        gen_tx_en_i, // Generator valid
  input  wire logic [3:0]  gen_txd_i,   // Generator nibble
  input  wire logic        gen_stb_i    // Generator strobe
);

  // ------------
  // Functions
  // ------------

  // Bin a finished frame by length, CRC and delimiter
  function automatic fcst_class_t classify(
    input logic [10:0] len,
    input logic        crc_ok,
    input logic        sfd_ok
  );
    fcst_class_t c;
    logic        under;
    logic        over;
    under        = (len < `FCST_LEN_MIN);
    over         = (len > `FCST_LEN_MAX);
    c.nosfd      = ~sfd_ok;
    // Fragment whatever the CRC
    c.frag       = sfd_ok & under;
    c.under_good = sfd_ok & under & crc_ok;
    c.inr_good   = sfd_ok & ~under & ~over & crc_ok;
    c.inr_bad    = sfd_ok & ~under & ~over & ~crc_ok;
    c.over_good  = sfd_ok & over & crc_ok;
    c.over_bad   = sfd_ok & over & ~crc_ok;
    return c;
  endfunction

  // Word index hit with aligned byte address
  function automatic logic hit(input logic [31:0] a, input logic [29:0] idx);
    return (a[31:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  // Counter slot of a word index
  function automatic logic [3:0] slot_of(input logic [29:0] idx);
    logic [29:0] d;
    d = idx - `FCST_IDX_RX_USH;
    return d[3:0];
  endfunction

  // ------------
  // Declarations
  // ------------

  logic        chk_en_ff;   // Checker enable
  logic        tx_src_ff;   // Tx source select
  logic [3:0]  stat_ff;     // Sticky events
  logic [3:0]  mask_ff;     // Event mask
  logic [3:0]  nxt_stat;    // Next events
  logic [31:0] prdata_ff;   // Read data
  logic        pready_ff;   // Ready
  logic        pslverr_ff;  // Error
  logic        irq_ff;      // Interrupt

  logic        apb_setup;   // Setup phase
  logic        apb_done;    // Access completes
  logic        apb_rd;      // Read setup
  logic        apb_wr;      // Write completes
  logic        hit_cnt;     // Counter window
  logic        hit_ctrl;    // Control word
  logic        hit_cfg2;    // Config word
  logic        hit_stat;    // Status word
  logic        hit_mask;    // Mask word
  logic        hit_any;     // Mapped address
  logic [3:0]  rd_slot;     // Counter slot
  logic [31:0] rd_mux;      // Read value

  logic        tx_dv;       // Selected tx valid
  logic [3:0]  tx_nib;      // Selected tx nibble
  logic        tx_stb;      // Selected tx strobe

  logic        rx_done;     // Rx frame end
  logic [10:0] rx_len;      // Rx length
  logic        rx_crc_ok;   // Rx CRC good
  logic        rx_sfd_ok;   // Rx delimiter seen
  logic        tx_done;     // Tx frame end
  logic [10:0] tx_len;      // Tx length
  logic        tx_crc_ok;   // Tx CRC good
  logic        tx_sfd_ok;   // Tx delimiter seen
  fcst_class_t rx_cls;      // Rx bins
  fcst_class_t tx_cls;      // Tx bins
  logic        rx_ev;       // Rx counted
  logic        tx_ev;       // Tx counted
  logic [3:0]  events;      // Interrupt events

  logic [15:0] cnt_val [16]; // Counter values
  logic [15:0] cnt_inc;      // Counter steps
  logic [15:0] cnt_clr;      // Counter clears
  logic [15:0] cnt_cy;       // Counter carries

  // ------------
  // APB decode
  // ------------

  // Decode on raw bus
  assign apb_setup = psel_i & ~penable_i;
  assign apb_done  = psel_i & penable_i & pready_ff;
  assign apb_rd    = apb_setup & ~pwrite_i;
  assign apb_wr    = apb_done & pwrite_i & hit_any;

  assign hit_cnt  = (paddr_i[1:0] == 2'b00)
                  && (paddr_i[31:2] >= `FCST_IDX_RX_USH)
                  && (paddr_i[31:2] <= `FCST_IDX_TX_NOSFD);
  assign hit_ctrl = hit(paddr_i, `FCST_IDX_CTRL);
  assign hit_cfg2 = hit(paddr_i, `FCST_IDX_CFG2);
  assign hit_stat = hit(paddr_i, `FCST_IDX_IRQ_STAT);
  assign hit_mask = hit(paddr_i, `FCST_IDX_IRQ_MASK);
  assign hit_any  = hit_cnt | hit_ctrl | hit_cfg2 | hit_stat | hit_mask;
  assign rd_slot  = slot_of(paddr_i[31:2]);

  // Read mux, narrow data in low bits
  assign rd_mux = hit_cnt  ? {16'h0000, cnt_val[rd_slot]} :
                  hit_ctrl ? {16'h0000, chk_en_ff, 15'h0000} :
                  hit_cfg2 ? {30'h0000_0000, tx_src_ff, 1'b0} :
                  hit_stat ? {28'h000_0000, stat_ff} :
                  hit_mask ? {28'h000_0000, mask_ff} : 32'h0000_0000;

  // ------------
  // Tx source
  // ------------

  // (RL14) generator or MAC data
  assign tx_dv  = tx_src_ff ? gen_tx_en_i : mii_tx_en_i;
  assign tx_nib = tx_src_ff ? gen_txd_i : mii_txd_i;
  assign tx_stb = tx_src_ff ? gen_stb_i : mii_stb_i;

  // ------------
  // Monitors
  // ------------

  // Wire receive stream
  fcst_frame_mon u_rx_mon (
    .mclk_i   (mclk_i),
    .rst_b_i  (rst_b_i),
    .run_i    (chk_en_ff),
    .dv_i     (rx_dv_i),
    .nib_i    (rx_nib_i),
    .stb_i    (rx_stb_i),
    .done_o   (rx_done),
    .len_o    (rx_len),
    .crc_ok_o (rx_crc_ok),
    .sfd_ok_o (rx_sfd_ok)
  );

  // Transmit stream from selected source
  fcst_frame_mon u_tx_mon (
    .mclk_i   (mclk_i),
    .rst_b_i  (rst_b_i),
    .run_i    (chk_en_ff),
    .dv_i     (tx_dv),
    .nib_i    (tx_nib),
    .stb_i    (tx_stb),
    .done_o   (tx_done),
    .len_o    (tx_len),
    .crc_ok_o (tx_crc_ok),
    .sfd_ok_o (tx_sfd_ok)
  );

  // Bins of each result
  assign rx_cls = classify(rx_len, rx_crc_ok, rx_sfd_ok);
  assign tx_cls = classify(tx_len, tx_crc_ok, tx_sfd_ok);

  // Gate again so a late pulse after disable is dropped
  // (RL13) count when enabled
  assign rx_ev = rx_done & chk_en_ff;
  assign tx_ev = tx_done & chk_en_ff;

  // ------------
  // Counter steps
  // ------------

  // Rx side bins
  // Highs step on a low wrap
  // (RL1) rx short good
  assign cnt_inc[slot_of(`FCST_IDX_RX_USL)]   = rx_ev & rx_cls.under_good;
  assign cnt_inc[slot_of(`FCST_IDX_RX_USH)]   = cnt_cy[slot_of(`FCST_IDX_RX_USL)];
  // (RL2) rx in-range errors
  assign cnt_inc[slot_of(`FCST_IDX_RX_IERR)]  = rx_ev & rx_cls.inr_bad;
  // (RL3) rx oversize errors
  assign cnt_inc[slot_of(`FCST_IDX_RX_OERR)]  = rx_ev & rx_cls.over_bad;
  // (RL4) rx fragments
  assign cnt_inc[slot_of(`FCST_IDX_RX_FRAG)]  = rx_ev & rx_cls.frag;
  // (RL5) rx no delimiter
  assign cnt_inc[slot_of(`FCST_IDX_RX_NOSFD)] = rx_ev & rx_cls.nosfd;

  // Tx side bins
  // (RL6) tx in-range good
  assign cnt_inc[slot_of(`FCST_IDX_TX_GDL)]   = tx_ev & tx_cls.inr_good;
  assign cnt_inc[slot_of(`FCST_IDX_TX_GDH)]   = cnt_cy[slot_of(`FCST_IDX_TX_GDL)];
  // (RL7) tx oversize good
  assign cnt_inc[slot_of(`FCST_IDX_TX_OSL)]   = tx_ev & tx_cls.over_good;
  assign cnt_inc[slot_of(`FCST_IDX_TX_OSH)]   = cnt_cy[slot_of(`FCST_IDX_TX_OSL)];
  // (RL8) tx short good
  assign cnt_inc[slot_of(`FCST_IDX_TX_USL)]   = tx_ev & tx_cls.under_good;
  assign cnt_inc[slot_of(`FCST_IDX_TX_USH)]   = cnt_cy[slot_of(`FCST_IDX_TX_USL)];
  // (RL9) tx in-range errors
  assign cnt_inc[slot_of(`FCST_IDX_TX_IERR)]  = tx_ev & tx_cls.inr_bad;
  // (RL10) tx oversize errors
  assign cnt_inc[slot_of(`FCST_IDX_TX_OERR)]  = tx_ev & tx_cls.over_bad;
  // (RL11) tx fragments
  assign cnt_inc[slot_of(`FCST_IDX_TX_FRAG)]  = tx_ev & tx_cls.frag;
  // (RL12) tx no delimiter
  assign cnt_inc[slot_of(`FCST_IDX_TX_NOSFD)] = tx_ev & tx_cls.nosfd;

  // ------------
  // Counters
  // ------------

  // Clear at the setup edge, the same edge that captures read data,
  // so no step can slip in between the snapshot and the clear
  // (RL15) read clears counter
  for (genvar i = 0; i < 16; i++) begin : g_cnt
    assign cnt_clr[i] = apb_rd & hit_cnt & (rd_slot == 4'(i));
    fcst_rc_cnt u_cnt (
      .mclk_i  (mclk_i),
      .rst_b_i (rst_b_i),
      .inc_i   (cnt_inc[i]),
      .clr_i   (cnt_clr[i]),
      .val_o   (cnt_val[i]),
      .cy_o    (cnt_cy[i])
    );
  end

  // ------------
  // Interrupts
  // ------------

  // Events: rx frame, tx frame, rx fault, tx fault
  // Fault: bad CRC or no SFD
  assign events = {tx_ev & (tx_cls.nosfd | ~tx_crc_ok),
                   rx_ev & (rx_cls.nosfd | ~rx_crc_ok),
                   tx_ev,
                   rx_ev};

  // Set wins over a write-one clear
  assign nxt_stat = (apb_wr && hit_stat) ?
                    ((stat_ff & ~pwdata_i[3:0]) | events) : (stat_ff | events);

  // ------------
  // Registers
  // ------------

  // Control bits written at access completion
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chk_en_ff <= 1'b0;
      tx_src_ff <= 1'b0;
      mask_ff   <= `FCST_RST_IRQ;
    end else if (apb_wr) begin
      // Checker enable
      if (hit_ctrl) begin
        chk_en_ff <= pwdata_i[`FCST_BIT_CHK_EN];
      end
      // Tx source select
      if (hit_cfg2) begin
        tx_src_ff <= pwdata_i[`FCST_BIT_TX_SRC];
      end
      // Mask
      if (hit_mask) begin
        mask_ff <= pwdata_i[3:0];
      end
    end
  end

  // Sticky status and level interrupt
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stat_ff <= `FCST_RST_IRQ;
      irq_ff  <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      irq_ff  <= |(nxt_stat & mask_ff);
    end
  end

  // No wait states
  // One wait-free access phase: answer set up at the setup edge
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= apb_setup;
      pslverr_ff <= apb_setup & ~hit_any;
      // Capture read data
      if (apb_rd) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  // Flops drive pins
  assign prdata_o  = prdata_ff;
  assign pready_o  = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign irq_o     = irq_ff;

endmodule // fcst_top

//--- verif/fcst_top_sva.sv
`timescale 1ns/10ps
`include "fcst_defs.svh"

// ---------------------------
// Port checker, top block
// ---------------------------
module fcst_top_sva (
  input wire logic        mclk_i,    // Core clock
  input wire logic        rst_b_i,   // Reset, low
  input wire logic        psel_i,    // APB select
  input wire logic        penable_i, // APB enable
  input wire logic        pwrite_i,  // APB write
  input wire logic [31:0] paddr_i,   // APB address
  input wire logic [31:0] pwdata_i,  // APB write data
  input wire logic [31:0] prdata_o,  // APB read data
  input wire logic        pready_o,  // APB ready
  input wire logic        pslverr_o, // APB error
  input wire logic        irq_o      // Interrupt
);
  wire [29:0] idx_w;      // Word index
  wire        cnt_w;      // Counter window
  wire        map_w;      // Mapped, aligned
  wire        rd_w;       // Read completes
  wire        wr_w;       // Write completes
  logic       en_seen_ff; // Enable ever set
  logic       mask_nz_ff; // Some mask bit set

  // Decode kept outside the flops
  assign idx_w = paddr_i[31:2];
  assign cnt_w = (idx_w >= `FCST_IDX_RX_USH) && (idx_w <= `FCST_IDX_TX_NOSFD);
  assign map_w = (paddr_i[1:0] == 2'b00) && (cnt_w || idx_w == `FCST_IDX_CTRL ||
                 idx_w == `FCST_IDX_CFG2 || idx_w == `FCST_IDX_IRQ_STAT ||
                 idx_w == `FCST_IDX_IRQ_MASK);
  assign rd_w  = pready_o && psel_i && penable_i && !pwrite_i;
  assign wr_w  = pready_o && psel_i && penable_i && pwrite_i;

  // Sticky: before any enable, counters must read zero
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) en_seen_ff <= 1'b0;
    else if (wr_w && idx_w == `FCST_IDX_CTRL && pwdata_i[15]) en_seen_ff <= 1'b1;
  end

  // Last mask write, nonzero or not
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) mask_nz_ff <= 1'b0;
    else if (wr_w && idx_w == `FCST_IDX_IRQ_MASK) mask_nz_ff <= |pwdata_i[3:0];
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  // Setup then access steps of a transfer
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_access;
    psel_i && penable_i;
  endsequence

  AST_READY_NEXT: assert property (s_setup |=> pready_o)
    else $error("ready missing after setup");
  AST_READY_ACCESS: assert property (pready_o |-> s_access)
    else $error("ready outside access");
  AST_READY_PULSE: assert property (pready_o |=> !pready_o)
    else $error("ready longer than a cycle");
  AST_ERR_READY: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  AST_UNMAP_ERR: assert property (pready_o && !map_w |-> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not refused");
  AST_MAP_OK: assert property (pready_o && map_w |-> !pslverr_o)
    else $error("mapped access refused");
  AST_CNT_WIDTH: assert property (rd_w && cnt_w |-> prdata_o[31:16] == 16'h0000)
    else $error("counter upper bits set");
  AST_CNT_IDLE: assert property (rd_w && cnt_w && !en_seen_ff |-> prdata_o == 32'h0)
    else $error("count while checker off");
  AST_CTRL_RSVD: assert property (rd_w && idx_w == `FCST_IDX_CTRL |-> prdata_o[14:0] == 15'h0)
    else $error("control reserved bits set");
  AST_IRQ_MASK: assert property (irq_o |-> mask_nz_ff || $past(mask_nz_ff))
    else $error("interrupt with all masked");
endmodule // fcst_top_sva

bind fcst_top fcst_top_sva fcst_top_sva_i (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o));

//--- verif/fcst_mii_src.sv
`timescale 1ns/10ps

// ---------------------------
// Nibble stream source model
// ---------------------------
module fcst_mii_src (
  input  wire logic  mclk_i, // Core clock
  output logic       dv_o,   // Frame valid
  output logic [3:0] nib_o,  // Nibble, low first
  output logic       stb_o   // Nibble strobe
);
  localparam logic [31:0] POLY = 32'hedb8_8320; // Reflected CRC-32

  initial begin
    dv_o = 1'b0;
    nib_o = 4'h0;
    stb_o = 1'b0;
  end

  // One strobed nibble per cycle
  task automatic put(input logic [3:0] n);
    dv_o <= 1'b1;
    stb_o <= 1'b1;
    nib_o <= n;
    @(posedge mclk_i);
  endtask

  // Preamble, delimiter, payload, CRC; bad flips one CRC bit
  task automatic send(input int nby, input bit bad, input bit nosfd);
    logic [31:0] c;
    logic [31:0] f;
    logic [7:0]  b;
    c = 32'hffff_ffff;
    f = 32'h0000_0000;
    for (int i = 0; i < 15; i++) put(4'h5);
    if (!nosfd) begin
      put(4'hd);
      for (int i = 0; i < nby; i++) begin
        if (i < nby - 4) begin
          b = i[7:0];
          c = c ^ {24'h00_0000, b};
          for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ POLY) : (c >> 1);
        end else begin
          if (i == nby - 4) f = ~c ^ {31'h0000_0000, bad};
          b = f[7:0];
          f = f >> 8;
        end
        put(b[3:0]);
        put(b[7:4]);
      end
    end
    // Released line shows no stale nibble
    dv_o <= 1'b0;
    stb_o <= 1'b0;
    nib_o <= ~nib_o;
    @(posedge mclk_i);
  endtask
endmodule // fcst_mii_src

//--- verif/frame_checker_statistics_bench.sv
`timescale 1ns/10ps
`include "fcst_defs.svh"

module frame_checker_statistics_bench;
  // ---------------------------
  // Signals
  // ---------------------------
  logic        mclk_i, rst_b_i, psel, penable, pwrite, pready, pslverr, irq;
  logic [31:0] paddr, pwdata, prdata;
  logic        rx_dv, rx_stb, m_en, m_stb, g_en, g_stb; // Stream controls
  logic [3:0]  rx_nib, m_nib, g_nib;                    // Stream nibbles
  int          errors, total_checks, cyc;
  logic [31:0] exp_rx [0:5] = '{0, 1, 2, 1, 2, 1};      // Rx bins
  logic [31:0] exp_tx [0:9] = '{0, 3, 0, 1, 0, 1, 1, 1, 2, 1}; // Tx bins

  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  fcst_top fcst_top_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq),
    .rx_dv_i(rx_dv), .rx_nib_i(rx_nib), .rx_stb_i(rx_stb), .mii_tx_en_i(m_en),
    .mii_txd_i(m_nib), .mii_stb_i(m_stb), .gen_tx_en_i(g_en), .gen_txd_i(g_nib),
    .gen_stb_i(g_stb));
  fcst_mii_src rx_src_i (.mclk_i(mclk_i), .dv_o(rx_dv), .nib_o(rx_nib), .stb_o(rx_stb));
  fcst_mii_src mac_src_i (.mclk_i(mclk_i), .dv_o(m_en), .nib_o(m_nib), .stb_o(m_stb));
  fcst_mii_src gen_src_i (.mclk_i(mclk_i), .dv_o(g_en), .nib_o(g_nib), .stb_o(g_stb));

  // ---------------------------
  // Shared tasks
  // ---------------------------
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask

  // One APB transfer; request held until ready is sampled
  task automatic apb(input logic wr, input logic [29:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge mclk_i);
    penable <= 1'b1;
    @(posedge mclk_i);
    while (pready !== 1'b1) begin
      @(posedge mclk_i);
    end
    chk("pready", 1, pready);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic wr(input logic [29:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    logic        e;
    apb(1'b1, idx, wd, d, e);
    chk($sformatf("wr err %h", idx), 0, e);
  endtask

  task automatic rd(input logic [29:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    apb(1'b0, idx, 32'h0000_0000, d, e);
    chk($sformatf("reg %h", idx), exp, d);
  endtask

  // Source 0 line, 1 MAC, 2 generator; settle for the counter step
  task automatic frame(input int s, input int n, input bit bad, input bit ns);
    case (s)
      0: rx_src_i.send(n, bad, ns);
      1: mac_src_i.send(n, bad, ns);
      default: gen_src_i.send(n, bad, ns);
    endcase
    repeat (4) @(posedge mclk_i);
  endtask

  // ---------------------------
  // Scenarios
  // ---------------------------
  task automatic t_reset_vals();
    for (int i = 0; i < 16; i++) rd(`FCST_IDX_RX_USH + i, 0);
    rd(`FCST_IDX_CTRL, 0);
    rd(`FCST_IDX_CFG2, 0);
  endtask

  task automatic t_disabled();
    frame(0, 64, 1, 0);
    frame(1, 64, 1, 0);
    rd(`FCST_IDX_RX_IERR, 0);
    rd(`FCST_IDX_TX_IERR, 0);
  endtask

  task automatic t_rx();
    wr(`FCST_IDX_CTRL, 32'hffff_ffff);
    rd(`FCST_IDX_CTRL, 32'h0000_8000);
    frame(0, 63, 0, 0);
    frame(0, 63, 1, 0);
    frame(0, 64, 1, 0);
    frame(0, 1518, 1, 0);
    frame(0, 1519, 1, 0);
    frame(0, 1518, 0, 0);
    frame(0, 80, 0, 1);
    for (int i = 0; i < 6; i++) rd(`FCST_IDX_RX_USH + i, exp_rx[i]);
    rd(`FCST_IDX_RX_FRAG, 0);
  endtask

  task automatic t_tx();
    wr(`FCST_IDX_CFG2, 32'h0000_0000);
    frame(1, 64, 0, 0);
    frame(1, 1518, 0, 0);
    frame(1, 1519, 0, 0);
    frame(1, 63, 0, 0);
    frame(1, 63, 1, 0);
    frame(1, 64, 1, 0);
    frame(1, 1519, 1, 0);
    frame(1, 80, 0, 1);
    frame(2, 64, 0, 0);
    wr(`FCST_IDX_CFG2, 32'hffff_ffff);
    rd(`FCST_IDX_CFG2, 32'h0000_0002);
    frame(2, 64, 0, 0);
    frame(1, 64, 0, 0);
    for (int i = 0; i < 10; i++) rd(`FCST_IDX_TX_GDH + i, exp_tx[i]);
  endtask

  task automatic t_irq();
    wr(`FCST_IDX_IRQ_STAT, 32'h0000_000f);
    rd(`FCST_IDX_IRQ_STAT, 0);
    frame(0, 64, 1, 0);
    rd(`FCST_IDX_IRQ_STAT, 32'h0000_0005);
    chk("irq masked", 0, irq);
    wr(`FCST_IDX_IRQ_MASK, 32'h0000_0004);
    repeat (2) @(posedge mclk_i);
    chk("irq raised", 1, irq);
    wr(`FCST_IDX_IRQ_STAT, 32'h0000_0004);
    repeat (2) @(posedge mclk_i);
    chk("irq cleared", 0, irq);
    rd(`FCST_IDX_IRQ_STAT, 32'h0000_0001);
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    logic        e;
    apb(1'b0, 30'h0000_4200, 32'h0000_0000, d, e);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, d);
  endtask

  // Cycle ceiling well above the expected run
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    cyc = 0;
    errors = 0;
    total_checks = 0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    rst_b_i = 1'b0;
    repeat (6) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    t_reset_vals();
    t_disabled();
    t_rx();
    t_tx();
    t_irq();
    t_unmapped();
    final_report();
  end
endmodule // frame_checker_statistics_bench
